// >>> design/lom_pkg.sv
/*
  lom_pkg: offsets, field positions, reset values, threshold tables,
  the mode-word view and the transmit start states.
  Assumes: 32-bit APB, byte addresses, one aligned word per register.
*/
package lom_pkg;

  // register byte offsets
  localparam logic [7:0]  OPMODE_OFS   = 8'h30;
  localparam logic [7:0]  STATUS_OFS   = 8'h34;

  // implemented bits, everything else reads zero
  localparam logic [31:0] OPMODE_WMASK = 32'hC3EE_C000;
  localparam logic [31:0] OPMODE_RESET = 32'h0000_0000;
  localparam logic [31:0] PORT_MASK    = 32'h0004_0000;

  // field positions
  localparam int unsigned ENH_BIT  = 31;
  localparam int unsigned RALL_BIT = 30;
  localparam int unsigned ONE_BIT  = 25;
  localparam int unsigned SCR_BIT  = 24;
  localparam int unsigned PCS_BIT  = 23;
  localparam int unsigned RATE_BIT = 22;
  localparam int unsigned SF_BIT   = 21;
  localparam int unsigned HBD_BIT  = 19;
  localparam int unsigned PORT_BIT = 18;
  localparam int unsigned CAP_BIT  = 17;
  localparam int unsigned LVL_LSB  = 14;

  // fifo fill count width in bits; the count itself is in bytes
  localparam int unsigned FILL_W   = 11;

  // start thresholds in bytes, index is the level field
  localparam logic [3:0][10:0] THR_10M  = {11'd160, 11'd128, 11'd96, 11'd72};
  localparam logic [3:0][10:0] THR_100M = {11'd1024, 11'd512, 11'd256, 11'd128};

  typedef struct packed {
    logic       enh_fair;
    logic       accept_all;
    logic       whitening;
    logic       pcs_on;
    logic       rate_10m;
    logic       full_frame;
    logic       hb_off;
    logic       port_media;
    logic       coll_fair;
    logic [1:0] level_sel;
  } lom_mode_t;

  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } lom_nib_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } lom_tx_state_t;

endpackage : lom_pkg

// >>> design/lom_top.sv
/*
  lom_top: upper operating mode word of the network controller, its
  APB slave, the port multiplexer, receive accept decision and the
  transmit start gate.
  Assumes: one clock; fifo, filter and both ports sit on that clock;
  soft_reset_i is a one-cycle pulse from the controller's reset bit.
*/
`timescale 1ns/1ps
module lom_top (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        soft_reset_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // transmit fifo
  input  wire logic [10:0] tx_fill_i,
  input  wire logic        tx_frame_ready_i,
  input  wire logic        tx_frame_sent_i,
  input  wire logic        tx_stopped_i,
  output logic             tx_start_o,
  // receive filter
  input  wire logic        rx_frame_end_i,
  input  wire logic        rx_addr_match_i,
  output logic             rx_accept_o,
  output logic             rx_status_word0_hit_o,
  // mac side nibble stream
  input  wire logic        mac_tx_en_i,
  input  wire logic [3:0]  mac_txd_i,
  output logic             mac_rx_dv_o,
  output logic [3:0]       mac_rxd_o,
  // serial port
  output logic             serial_port_tx_en_o,
  output logic             serial_port_txd_o,
  input  wire logic        serial_port_rx_dv_i,
  input  wire logic        serial_port_rxd_i,
  // media symbol port
  output logic             media_symbol_port_tx_en_o,
  output logic [3:0]       media_symbol_port_txd_o,
  input  wire logic        media_symbol_port_rx_dv_i,
  input  wire logic [3:0]  media_symbol_port_rxd_i,
  // mode to the rest of the controller
  output logic             enhanced_backoff_fairness_o,
  output logic             collision_fairness_enable_o,
  output logic             symbol_whitening_o,
  output logic             pcs_active_o,
  output logic             media_ctrl_internal_o,
  output logic             sqe_gen_en_o
);

  ////////////////////////////////////////////////////////////////////
  // register state

  logic [31:0]       opmode_q, opmode_d;
  lom_pkg::lom_mode_t mode;
  logic              pready_q, pready_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              pslverr_q, pslverr_d;
  logic              access, wr_now, hit_mode, hit_stat;
  logic [31:0]       lane_mask;
  logic [31:0]       status_word;
  logic              gate_start, gate_busy;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  function automatic lom_pkg::lom_mode_t view(input logic [31:0] w);
    view.enh_fair   = w[lom_pkg::ENH_BIT];
    view.accept_all = w[lom_pkg::RALL_BIT];
    view.whitening  = w[lom_pkg::SCR_BIT];
    view.pcs_on     = w[lom_pkg::PCS_BIT];
    view.rate_10m   = w[lom_pkg::RATE_BIT];
    view.full_frame = w[lom_pkg::SF_BIT];
    view.hb_off     = w[lom_pkg::HBD_BIT];
    view.port_media = w[lom_pkg::PORT_BIT];
    view.coll_fair  = w[lom_pkg::CAP_BIT];
    view.level_sel  = w[lom_pkg::LVL_LSB +: 2];
  endfunction : view

  assign mode = view(opmode_q);

  ////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, write lands with pready

  always_comb begin
    access    = psel_i && penable_i;
    wr_now    = access && pready_q && pwrite_i;
    hit_mode  = 1'b0;
    hit_stat  = 1'b0;
    if (paddr_i == lom_pkg::OPMODE_OFS) begin
      hit_mode = 1'b1;
    end else if (paddr_i == lom_pkg::STATUS_OFS) begin
      hit_stat = 1'b1;
    end
    lane_mask = strb_mask(pstrb_i);
  end

  always_comb begin
    status_word       = 32'h0000_0000;
    status_word[0]    = gate_busy;
    status_word[1]    = mode.port_media;
    status_word[2]    = tx_stopped_i;
    status_word[3]    = tx_frame_ready_i;
  end

  always_comb begin
    pready_d  = access && !pready_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (access && !pready_q) begin
      prdata_d  = 32'h0000_0000;
      if (hit_mode) begin
        prdata_d = pwrite_i ? 32'h0000_0000 : (opmode_q & lom_pkg::OPMODE_WMASK);
      end else if (hit_stat) begin
        prdata_d = pwrite_i ? 32'h0000_0000 : status_word;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready_o  = pready_q;
  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q;

  ////////////////////////////////////////////////////////////////////
  // mode word
  // bit 25 is stored as written; a missing one is the caller's slip,
  // reading it back lets driver code spot that

  always_comb begin
    opmode_d = opmode_q;
    if (soft_reset_i) begin
      opmode_d = (lom_pkg::OPMODE_RESET & ~lom_pkg::PORT_MASK)
               | (opmode_q & lom_pkg::PORT_MASK);
    end else if (wr_now && hit_mode) begin
      opmode_d = ((opmode_q & ~lane_mask) | (pwdata_i & lane_mask))
               & lom_pkg::OPMODE_WMASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      opmode_q <= lom_pkg::OPMODE_RESET;
    end else begin
      opmode_q <= opmode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // direct mode outputs, straight off the word flops

  assign enhanced_backoff_fairness_o = opmode_q[lom_pkg::ENH_BIT];
  assign collision_fairness_enable_o = opmode_q[lom_pkg::CAP_BIT];
  assign symbol_whitening_o          = opmode_q[lom_pkg::SCR_BIT];
  assign pcs_active_o                = opmode_q[lom_pkg::PCS_BIT];

  ////////////////////////////////////////////////////////////////////
  // receive accept and match report

  logic rx_accept_q, rx_accept_d;
  logic rx_hit_q, rx_hit_d;

  always_comb begin
    rx_accept_d = 1'b0;
    rx_hit_d    = rx_hit_q;
    if (rx_frame_end_i) begin
      rx_accept_d = mode.accept_all || rx_addr_match_i;
      rx_hit_d    = rx_addr_match_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rx_accept_q <= 1'b0;
      rx_hit_q    <= 1'b0;
    end else begin
      rx_accept_q <= rx_accept_d;
      rx_hit_q    <= rx_hit_d;
    end
  end

  assign rx_accept_o           = rx_accept_q;
  assign rx_status_word0_hit_o = rx_hit_q;

  ////////////////////////////////////////////////////////////////////
  // port multiplexer; one registered stage each way after the mux so that a port
  // switch never glitches a pin mid cycle

  lom_pkg::lom_nib_t ser_tx_q, ser_tx_d;
  lom_pkg::lom_nib_t med_tx_q, med_tx_d;
  lom_pkg::lom_nib_t rx_q, rx_d;
  logic              ctrl_int_q, ctrl_int_d;
  logic              sqe_q, sqe_d;
  logic              ser_dv_s1, ser_dv_s2, ser_d_s1, ser_d_s2;
  logic              med_dv_s1, med_dv_s2;
  logic [3:0]        med_d_s1, med_d_s2;

  // port pins pass two flops first
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ser_dv_s1 <= 1'b0;
      ser_dv_s2 <= 1'b0;
      ser_d_s1  <= 1'b0;
      ser_d_s2  <= 1'b0;
      med_dv_s1 <= 1'b0;
      med_dv_s2 <= 1'b0;
      med_d_s1  <= 4'h0;
      med_d_s2  <= 4'h0;
    end else begin
      ser_dv_s1 <= serial_port_rx_dv_i;
      ser_dv_s2 <= ser_dv_s1;
      ser_d_s1  <= serial_port_rxd_i;
      ser_d_s2  <= ser_d_s1;
      med_dv_s1 <= media_symbol_port_rx_dv_i;
      med_dv_s2 <= med_dv_s1;
      med_d_s1  <= media_symbol_port_rxd_i;
      med_d_s2  <= med_d_s1;
    end
  end

  always_comb begin
    ser_tx_d = '0;
    med_tx_d = '0;
    rx_d     = '0;
    if (mode.port_media) begin
      med_tx_d.en = mac_tx_en_i;
      med_tx_d.d  = mac_txd_i;
      rx_d.en     = med_dv_s2;
      rx_d.d      = med_d_s2;
    end else begin
      ser_tx_d.en = mac_tx_en_i;
      ser_tx_d.d  = {3'b000, mac_txd_i[0]};
      rx_d.en     = ser_dv_s2;
      rx_d.d      = {3'b000, ser_d_s2};
    end
    ctrl_int_d = mode.pcs_on && mode.port_media;
    sqe_d      = !mode.hb_off && !mode.port_media;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ser_tx_q   <= '0;
      med_tx_q   <= '0;
      rx_q       <= '0;
      ctrl_int_q <= 1'b0;
      sqe_q      <= 1'b0;
    end else begin
      ser_tx_q   <= ser_tx_d;
      med_tx_q   <= med_tx_d;
      rx_q       <= rx_d;
      ctrl_int_q <= ctrl_int_d;
      sqe_q      <= sqe_d;
    end
  end

  assign serial_port_tx_en_o       = ser_tx_q.en;
  assign serial_port_txd_o         = ser_tx_q.d[0];
  assign media_symbol_port_tx_en_o = med_tx_q.en;
  assign media_symbol_port_txd_o   = med_tx_q.d;
  assign mac_rx_dv_o               = rx_q.en;
  assign mac_rxd_o                 = rx_q.d;
  assign media_ctrl_internal_o     = ctrl_int_q;
  assign sqe_gen_en_o              = sqe_q;

  ////////////////////////////////////////////////////////////////////
  // transmit start gate

  lom_tx_gate u_gate (
    .ref_clk_i     (ref_clk_i),
    .rstn_i        (rstn_i),
    .flush_i       (soft_reset_i || tx_stopped_i),
    .rate_10m_i    (mode.rate_10m),
    .full_frame_i  (mode.full_frame),
    .level_sel_i   (mode.level_sel),
    .fill_i        (tx_fill_i),
    .frame_ready_i (tx_frame_ready_i),
    .frame_sent_i  (tx_frame_sent_i),
    .start_o       (gate_start),
    .busy_o        (gate_busy)
  );

  assign tx_start_o = gate_start;

endmodule : lom_top

// >>> design/lom_tx_gate.sv
/*
  lom_tx_gate: decides when a buffered frame may start on the wire.
  Assumes: fill level and frame_ready come from the fifo on the same
  clock; frame_sent pulses once the started frame has left.
*/
`timescale 1ns/1ps
module lom_tx_gate (
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      flush_i,
  // mode
  input  wire logic                      rate_10m_i,
  input  wire logic                      full_frame_i,
  input  wire logic [1:0]                level_sel_i,
  // fifo side
  input  wire logic [lom_pkg::FILL_W-1:0] fill_i,
  input  wire logic                      frame_ready_i,
  input  wire logic                      frame_sent_i,
  // start
  output logic                           start_o,
  output logic                           busy_o
);

  lom_pkg::lom_tx_state_t state_q, state_d;
  logic                   start_q, start_d;
  logic [10:0]            thr;
  logic                   go;

  always_comb begin
    thr = rate_10m_i ? lom_pkg::THR_10M[level_sel_i] : lom_pkg::THR_100M[level_sel_i];
    if (full_frame_i) begin
      go = frame_ready_i;
    end else begin
      // above level or short whole frame
      go = (fill_i > thr) || frame_ready_i;
    end
  end

  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    case (state_q)
      lom_pkg::TX_IDLE: begin
        if (go && !flush_i) begin
          start_d = 1'b1;
          state_d = lom_pkg::TX_SEND;
        end
      end
      lom_pkg::TX_SEND: begin
        if (frame_sent_i || flush_i) begin
          state_d = lom_pkg::TX_IDLE;
        end
      end
      default: state_d = lom_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_q <= lom_pkg::TX_IDLE;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
    end
  end

  assign start_o = start_q;
  assign busy_o  = (state_q == lom_pkg::TX_SEND);

endmodule : lom_tx_gate

// >>> test/lom_top_sva.sv
/*
  lom_top_sva: concurrent checks on the ports of lom_top.
  Assumes: one clock, sync active-low reset, full-word mode writes.
*/
`timescale 1ns/1ps
module lom_top_sva (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic        soft_reset_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  // transmit and receive
  input wire logic [10:0] tx_fill_i,
  input wire logic        tx_frame_ready_i,
  input wire logic        tx_stopped_i,
  input wire logic        tx_start_o,
  input wire logic        rx_frame_end_i,
  input wire logic        rx_addr_match_i,
  input wire logic        rx_accept_o,
  input wire logic        rx_status_word0_hit_o,
  // mode
  input wire logic        enhanced_backoff_fairness_o,
  input wire logic        collision_fairness_enable_o,
  input wire logic        symbol_whitening_o,
  input wire logic        pcs_active_o,
  input wire logic        media_ctrl_internal_o
);
  logic wr_mode;
  // soft reset wins over a write in the same cycle
  always_comb wr_mode = psel_i & penable_i & pready_o & pwrite_i & !soft_reset_i
                        & (paddr_i == lom_pkg::OPMODE_OFS) & (pstrb_i == 4'hf);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_enh; wr_mode |=> enhanced_backoff_fairness_o == $past(pwdata_i[31]); endproperty
  a_enh: assert property (p_enh)
    else $error("enhanced fairness differs from written bit");
  property p_cap; wr_mode |=> collision_fairness_enable_o == $past(pwdata_i[17]); endproperty
  a_cap: assert property (p_cap)
    else $error("capture resolution differs from written bit");
  property p_whiten; wr_mode |=> symbol_whitening_o == $past(pwdata_i[24]); endproperty
  a_whiten: assert property (p_whiten)
    else $error("scrambler enable differs from written bit");
  property p_pcs; wr_mode |=> pcs_active_o == $past(pwdata_i[23]); endproperty
  a_pcs: assert property (p_pcs)
    else $error("pcs enable differs from written bit");
  property p_mii; !pcs_active_o [*2] |-> !media_ctrl_internal_o; endproperty
  a_mii: assert property (p_mii)
    else $error("internal control without pcs");
  property p_rx_hit; rx_frame_end_i && rx_addr_match_i |=> rx_accept_o && rx_status_word0_hit_o;
  endproperty
  a_rx_hit: assert property (p_rx_hit)
    else $error("matched frame not accepted");
  property p_start;
    tx_start_o |-> !$past(tx_stopped_i) && !$past(soft_reset_i)
      && ($past(tx_frame_ready_i) || $past(tx_fill_i) > lom_pkg::THR_10M[0]);
  endproperty
  a_start: assert property (p_start)
    else $error("transmit start without cause");
  property p_unmapped;
    pready_o && paddr_i != lom_pkg::OPMODE_OFS && paddr_i != lom_pkg::STATUS_OFS |-> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without error");
  property p_rsvd;
    pready_o && !pwrite_i && paddr_i == lom_pkg::OPMODE_OFS
      |-> (prdata_o & ~lom_pkg::OPMODE_WMASK) == 32'h0000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("undescribed mode bit reads nonzero");
  c_wr: cover property (wr_mode);
  c_start: cover property (tx_start_o);
  c_err: cover property (pslverr_o);
endmodule : lom_top_sva

bind lom_top lom_top_sva u_sva (.*);

// >>> test/test_lan_operating_mode_upper.sv
/*
  test_lan_operating_mode_upper: self-checking bench for lom_top.
  Assumes: one-wait-state apb slave, registered outputs per hand-over.
*/
`timescale 1ns/1ps
module test_lan_operating_mode_upper;
  logic        ref_clk_i = 1'b0, rstn_i = 1'b0, soft_reset_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd, d;
  logic [3:0]  pstrb_i = 4'hf;
  logic        pready_o, pslverr_o, err;
  logic [10:0] tx_fill_i = 11'h000, thr;
  logic        tx_frame_ready_i = 1'b0, tx_frame_sent_i = 1'b0, tx_stopped_i = 1'b1;
  logic        tx_start_o, rx_frame_end_i = 1'b0, rx_addr_match_i = 1'b0;
  logic        rx_accept_o, rx_status_word0_hit_o, mac_tx_en_i = 1'b0;
  logic [3:0]  mac_txd_i = 4'h0, mac_rxd_o, media_symbol_port_txd_o;
  logic [3:0]  media_symbol_port_rxd_i = 4'h0;
  logic        mac_rx_dv_o, serial_port_tx_en_o, serial_port_txd_o;
  logic        serial_port_rx_dv_i = 1'b0, serial_port_rxd_i = 1'b0;
  logic        media_symbol_port_tx_en_o, media_symbol_port_rx_dv_i = 1'b0;
  logic        enhanced_backoff_fairness_o, collision_fairness_enable_o;
  logic        symbol_whitening_o, pcs_active_o, media_ctrl_internal_o, sqe_gen_en_o;
  logic [31:0] seed = 32'h0000_15c7;
  int          n_mismatch = 0;
  int          check_count = 0;

  lom_top dut (.*);

  always #50 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // no fixed latency assumed, watchdog ends a hang
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // one set, written stopped, mode last
  task automatic wmode(input logic [31:0] v);
    tx_stopped_i <= 1'b1;
    apb(1'b1, lom_pkg::OPMODE_OFS, v | 32'h0200_0000);
  endtask : wmode

  task automatic try_start(input logic [10:0] f, input logic rdy, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge ref_clk_i);
    tx_fill_i <= f;
    tx_frame_ready_i <= rdy;
    repeat (3) begin
      @(posedge ref_clk_i);
      #1 seen = seen | tx_start_o;
    end
    chk(seen, exp);
    @(posedge ref_clk_i);
    tx_fill_i <= 11'h000;
    tx_frame_ready_i <= 1'b0;
    tx_frame_sent_i <= 1'b1;
    @(posedge ref_clk_i);
    tx_frame_sent_i <= 1'b0;
  endtask : try_start

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    apb(1'b0, lom_pkg::OPMODE_OFS, 32'h0000_0000);
    chk(rd, lom_pkg::OPMODE_RESET);
    apb(1'b1, 8'h38, 32'hffff_ffff);
    chk(err, 1'b1);
    apb(1'b0, lom_pkg::OPMODE_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 12; i++) begin
      d = rnd();
      if (i < 4) d[24:23] = 2'b00;
      if (d[18]) d[19] = 1'b1;
      wmode(d);
      d = (d | 32'h0200_0000) & lom_pkg::OPMODE_WMASK;
      apb(1'b0, lom_pkg::OPMODE_OFS, 32'h0000_0000);
      chk(rd, d);
      chk(enhanced_backoff_fairness_o, d[31]);
      chk(collision_fairness_enable_o, d[17]);
      chk(symbol_whitening_o, d[24]);
      chk(pcs_active_o, d[23]);
      chk(media_ctrl_internal_o, d[23] & d[18]);
      chk(sqe_gen_en_o, !d[19] && !d[18]);
      @(posedge ref_clk_i);
      mac_tx_en_i <= 1'b1;
      mac_txd_i <= seed[7:4];
      media_symbol_port_rx_dv_i <= seed[8];
      media_symbol_port_rxd_i <= seed[12:9];
      serial_port_rx_dv_i <= seed[13];
      serial_port_rxd_i <= seed[14];
      repeat (5) @(posedge ref_clk_i);
      // symbol coding would alter the nibbles, so plain mii only
      if (d[18] && d[24:23] == 2'b00) begin
        chk({media_symbol_port_tx_en_o, media_symbol_port_txd_o}, {1'b1, mac_txd_i});
        chk({mac_rx_dv_o, mac_rxd_o}, {media_symbol_port_rx_dv_i, media_symbol_port_rxd_i});
        chk(serial_port_tx_en_o, 1'b0);
      end else if (!d[18]) begin
        chk({serial_port_tx_en_o, serial_port_txd_o}, {1'b1, mac_txd_i[0]});
        chk(mac_rx_dv_o, serial_port_rx_dv_i);
        chk(mac_rxd_o, {3'b000, serial_port_rxd_i});
        chk(media_symbol_port_tx_en_o, 1'b0);
      end
    end
    wmode(32'hffff_ffff);
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b0;
    apb(1'b0, lom_pkg::OPMODE_OFS, 32'h0000_0000);
    chk(rd, lom_pkg::PORT_MASK);
    // port kept, transmit stopped, gate idle
    apb(1'b0, lom_pkg::STATUS_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    apb(1'b0, lom_pkg::OPMODE_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // top byte lane only
    pstrb_i <= 4'h8;
    wmode(32'hffff_ffff);
    pstrb_i <= 4'hf;
    apb(1'b0, lom_pkg::OPMODE_OFS, 32'h0000_0000);
    chk(rd, lom_pkg::OPMODE_WMASK & 32'hff00_0000);
    for (int k = 0; k < 4; k++) begin
      wmode({1'b0, k[1], 30'h0000_0000});
      @(posedge ref_clk_i);
      rx_frame_end_i <= 1'b1;
      rx_addr_match_i <= k[0];
      @(posedge ref_clk_i);
      rx_frame_end_i <= 1'b0;
      #1 chk({rx_accept_o, rx_status_word0_hit_o}, {k[1] | k[0], k[0]});
    end
    for (int k = 0; k < 8; k++) begin
      wmode({9'h000, k[2], 6'h00, k[1:0], 14'h0000});
      tx_stopped_i <= 1'b0;
      thr = k[2] ? lom_pkg::THR_10M[k[1:0]] : lom_pkg::THR_100M[k[1:0]];
      try_start(thr, 1'b0, 1'b0);
      try_start(thr + 11'h001, 1'b0, 1'b1);
      try_start(11'h004, 1'b1, 1'b1);
    end
    wmode(32'h0020_0000);
    tx_stopped_i <= 1'b0;
    try_start(11'h7ff, 1'b0, 1'b0);
    try_start(11'h7ff, 1'b1, 1'b1);
    tx_stopped_i <= 1'b1;
    try_start(11'h7ff, 1'b1, 1'b0);
    summarize();
  end
endmodule : test_lan_operating_mode_upper
